//--- core/irq_src.sv
// Interrupt sources, reset-cause register and context shadow with AXI4-Lite access
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Reset-cause bits 6 and 5 are unimplemented and read zero.
// - Bit 4 soft-reset flag, read/write, one after power-on.
// - Bit 0 brownout status, read/write, zero after power-on.
// - External pins trigger on rising edge if select is one, else falling.
// - A valid selected edge sets that pin's flag.
// - Clearing an external enable stops its request.
// - Enabled external interrupts wake the core from sleep.
// - After wake, vector only when global enable is set.
// - Priorities of ext 1,2,3 from ctrl three bit 6, 7, ctrl two bit 1.
// - External interrupt zero is always high priority.
// - 8-bit mode sets timer flag when count wraps ff to 00.
// - 16-bit mode sets timer flag when count wraps ffff to 0000.
// - Timer interrupt enable at control one bit 5.
// - Timer priority from control two bit 2.
// - Change on port B bits 7..4 sets flag at control one bit 0.
// - Port-change enable at control one bit 3.
// - Port-change priority from control two bit 0.
// - Interrupt entry pushes return PC onto the return stack.
// - Entry copies working, status and bank registers into shadow.
// - Only input pins compare against value latched at last port read.
// - Port change wakes from sleep; port access ends mismatch.
module irq_src #(
    parameter int PC_WIDTH = 21
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // AXI4-Lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Pins and port state
    input  wire logic [3:0]          ext_irq_pins,
    input  wire logic [7:4]          port_b_pins,
    input  wire logic [7:4]          port_b_dir_in,
    input  wire logic                port_b_access,
    // Timer zero counts
    input  wire logic [7:0]          timer_zero_count_low,
    input  wire logic [7:0]          timer_zero_count_high,
    // Core side
    input  wire logic                core_sleeping,
    input  wire logic                irq_entry,
    input  wire logic [PC_WIDTH-1:0] return_pc,
    input  wire logic [7:0]          working_register,
    input  wire logic [7:0]          core_status,
    input  wire logic [7:0]          bank_select_register,
    output logic                     irq_high_req,
    output logic                     irq_low_req,
    output logic                     wake_req,
    output logic                     vector_req,
    output logic                     stack_push,
    output logic [PC_WIDTH-1:0]      stack_push_pc,
    output logic [7:0]               shadow_working,
    output logic [7:0]               shadow_status,
    output logic [7:0]               shadow_bank
);

    logic [7:0] reset_cause_and_priority_mode_reg;
    logic [7:0] ctrl_one_reg;
    logic [7:0] ctrl_two_reg;
    logic [7:0] ctrl_three_reg;
    logic [3:0] pin_sync1_reg;
    logic [3:0] pin_sync2_reg;
    logic [3:0] pin_prev_reg;
    logic [7:4] port_latch_reg;
    logic [15:0] tmr_prev_reg;
    logic       aw_held_reg;
    logic       w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // -------------------------------------------------------------
    // Event detection
    // -------------------------------------------------------------
    logic [3:0] ext_edge_select;
    logic [3:0] ext_event;
    logic [3:0] rise;
    logic [3:0] fall;
    logic       tmr_event;
    logic       pchg_event;
    logic       mode16;

    assign ext_edge_select = ctrl_two_reg[irq_src_pkg::BIT_EDGE_LSB+3:irq_src_pkg::BIT_EDGE_LSB];
    assign rise = pin_sync2_reg & ~pin_prev_reg;
    assign fall = ~pin_sync2_reg & pin_prev_reg;
    assign ext_event = (ext_edge_select & rise) | (~ext_edge_select & fall);
    assign mode16 = ~ctrl_two_reg[irq_src_pkg::BIT_T16_MODE];
    assign tmr_event = mode16
        ? (tmr_prev_reg == 16'hffff && {timer_zero_count_high, timer_zero_count_low} == 16'h0000)
        : (tmr_prev_reg[7:0] == 8'hff && timer_zero_count_low == 8'h00);
    assign pchg_event = |((port_b_pins ^ port_latch_reg) & port_b_dir_in);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pin_sync1_reg <= 4'h0;
            pin_sync2_reg <= 4'h0;
            pin_prev_reg  <= 4'h0;
        end else begin
            pin_sync1_reg <= ext_irq_pins;
            pin_sync2_reg <= pin_sync1_reg;
            pin_prev_reg  <= pin_sync2_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tmr_prev_reg <= 16'h0000;
        end else begin
            tmr_prev_reg <= {timer_zero_count_high, timer_zero_count_low};
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            port_latch_reg <= 4'h0;
        end else if (port_b_access) begin
            port_latch_reg <= port_b_pins;
        end
    end

    // -------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------
    logic        wr_fire;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_byte;
    logic        wr_ok;
    logic [31:0] rd_word;
    logic        rd_ok;

    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_addr = aw_addr_reg;
    assign wr_byte = w_data_reg[7:0];
    assign wr_ok = w_strb_reg[0] && (wr_addr == irq_src_pkg::OFF_RESET_CAUSE || wr_addr == irq_src_pkg::OFF_CTRL_ONE
        || wr_addr == irq_src_pkg::OFF_CTRL_TWO || wr_addr == irq_src_pkg::OFF_CTRL_THREE);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= irq_src_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ok || !w_strb_reg[0] && wr_addr <= irq_src_pkg::OFF_STATUS)
                    ? irq_src_pkg::RESP_OKAY : irq_src_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        unique case ({s_axi_araddr[7:2], 2'b00})
            irq_src_pkg::OFF_RESET_CAUSE: rd_word[7:0] = reset_cause_and_priority_mode_reg & 8'h9f;
            irq_src_pkg::OFF_CTRL_ONE:    rd_word[7:0] = ctrl_one_reg;
            irq_src_pkg::OFF_CTRL_TWO:    rd_word[7:0] = ctrl_two_reg;
            irq_src_pkg::OFF_CTRL_THREE:  rd_word[7:0] = ctrl_three_reg;
            irq_src_pkg::OFF_STATUS:      rd_word[7:0] = {3'b000, vector_req, wake_req, irq_low_req,
                                                          irq_high_req, |port_latch_reg};
            default:                      rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= irq_src_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? irq_src_pkg::RESP_OKAY : irq_src_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Registers; hardware set wins over software clear
    // -------------------------------------------------------------
    logic wr_rc;
    logic wr_c1;
    logic wr_c2;
    logic wr_c3;

    assign wr_rc = wr_fire && w_strb_reg[0] && wr_addr == irq_src_pkg::OFF_RESET_CAUSE;
    assign wr_c1 = wr_fire && w_strb_reg[0] && wr_addr == irq_src_pkg::OFF_CTRL_ONE;
    assign wr_c2 = wr_fire && w_strb_reg[0] && wr_addr == irq_src_pkg::OFF_CTRL_TWO;
    assign wr_c3 = wr_fire && w_strb_reg[0] && wr_addr == irq_src_pkg::OFF_CTRL_THREE;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reset_cause_and_priority_mode_reg <= irq_src_pkg::RESET_CAUSE_RST;
        end else if (wr_rc) begin
            reset_cause_and_priority_mode_reg <= (wr_byte & irq_src_pkg::RESET_CAUSE_WMASK)
                | (reset_cause_and_priority_mode_reg & ~irq_src_pkg::RESET_CAUSE_WMASK) | 8'h10 & wr_byte;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_one_reg <= 8'h00;
        end else begin
            if (wr_c1) begin
                ctrl_one_reg <= wr_byte;
            end
            if (tmr_event)    ctrl_one_reg[irq_src_pkg::BIT_TMR0_FLAG] <= 1'b1;
            if (ext_event[0]) ctrl_one_reg[irq_src_pkg::BIT_EXT0_FLAG] <= 1'b1;
            if (pchg_event)   ctrl_one_reg[irq_src_pkg::BIT_PCHG_FLAG] <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_two_reg <= irq_src_pkg::CTRL_TWO_RST;
        end else if (wr_c2) begin
            ctrl_two_reg <= wr_byte;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_three_reg <= irq_src_pkg::CTRL_THREE_RST;
        end else begin
            if (wr_c3) begin
                ctrl_three_reg <= wr_byte;
            end
            if (ext_event[1]) ctrl_three_reg[irq_src_pkg::BIT_EXT1_FLAG] <= 1'b1;
            if (ext_event[2]) ctrl_three_reg[irq_src_pkg::BIT_EXT2_FLAG] <= 1'b1;
            if (ext_event[3]) ctrl_three_reg[irq_src_pkg::BIT_EXT3_FLAG] <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Requests, wake and vector
    // -------------------------------------------------------------
    logic [5:0] src_active;
    logic [5:0] src_high;
    logic       prio_en;
    logic       any_high;
    logic       any_low;

    assign prio_en = reset_cause_and_priority_mode_reg[irq_src_pkg::BIT_PRIO_EN];
    // Order: ext0, ext1, ext2, ext3, timer, port change
    assign src_active = {
        ctrl_one_reg[irq_src_pkg::BIT_PCHG_FLAG] & ctrl_one_reg[irq_src_pkg::BIT_PCHG_EN],
        ctrl_one_reg[irq_src_pkg::BIT_TMR0_FLAG] & ctrl_one_reg[irq_src_pkg::BIT_TMR0_EN],
        ctrl_three_reg[irq_src_pkg::BIT_EXT3_FLAG] & ctrl_three_reg[irq_src_pkg::BIT_EXT3_EN],
        ctrl_three_reg[irq_src_pkg::BIT_EXT2_FLAG] & ctrl_three_reg[irq_src_pkg::BIT_EXT2_EN],
        ctrl_three_reg[irq_src_pkg::BIT_EXT1_FLAG] & ctrl_three_reg[irq_src_pkg::BIT_EXT1_EN],
        ctrl_one_reg[irq_src_pkg::BIT_EXT0_FLAG] & ctrl_one_reg[irq_src_pkg::BIT_EXT0_EN]};
    assign src_high = {
        ctrl_two_reg[irq_src_pkg::BIT_PCHG_PRIO],
        ctrl_two_reg[irq_src_pkg::BIT_TMR0_PRIO],
        ctrl_two_reg[irq_src_pkg::BIT_EXT3_PRIO],
        ctrl_three_reg[irq_src_pkg::BIT_EXT2_PRIO],
        ctrl_three_reg[irq_src_pkg::BIT_EXT1_PRIO],
        1'b1};
    assign any_high = |(src_active & (src_high | {6{~prio_en}}));
    assign any_low  = prio_en && |(src_active & ~src_high);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_high_req <= 1'b0;
            irq_low_req  <= 1'b0;
            wake_req     <= 1'b0;
            vector_req   <= 1'b0;
        end else begin
            irq_high_req <= any_high;
            irq_low_req  <= any_low;
            wake_req     <= core_sleeping && |src_active;
            vector_req   <= |src_active && ctrl_one_reg[irq_src_pkg::BIT_GIE];
        end
    end

    // -------------------------------------------------------------
    // Context saving on entry
    // -------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stack_push     <= 1'b0;
            stack_push_pc  <= '0;
            shadow_working <= 8'h00;
            shadow_status  <= 8'h00;
            shadow_bank    <= 8'h00;
        end else begin
            stack_push <= irq_entry;
            if (irq_entry) begin
                stack_push_pc  <= return_pc;
                shadow_working <= working_register;
                shadow_status  <= core_status;
                shadow_bank    <= bank_select_register;
            end
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    sequence s_rise_seen;
        !pin_sync2_reg[0] ##1 pin_sync2_reg[0];
    endsequence
    property p_ext0_rise;
        @(posedge mclk) disable iff (!resetn)
        s_rise_seen ##0 ext_edge_select[0] |=> ctrl_one_reg[irq_src_pkg::BIT_EXT0_FLAG];
    endproperty
    a_ext0_rise: assert property (p_ext0_rise) else $error("ext0 rising edge lost");

    property p_rsv_read;
        @(posedge mclk) disable iff (!resetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00 |=> s_axi_rdata[6:5] == 2'b00;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("reserved bits not zero");

    property p_flag_hold;
        @(posedge mclk) disable iff (!resetn)
        ctrl_one_reg[irq_src_pkg::BIT_TMR0_FLAG] && !wr_c1 |=> ctrl_one_reg[irq_src_pkg::BIT_TMR0_FLAG];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("timer flag dropped");

    property p_tmr_set;
        @(posedge mclk) disable iff (!resetn)
        tmr_event |=> ctrl_one_reg[irq_src_pkg::BIT_TMR0_FLAG];
    endproperty
    a_tmr_set: assert property (p_tmr_set) else $error("timer overflow not flagged");

    property p_disabled_quiet;
        @(posedge mclk) disable iff (!resetn)
        src_active == 6'h00 |=> !irq_high_req && !irq_low_req;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("request without enabled flag");

    property p_ext0_high;
        @(posedge mclk) disable iff (!resetn)
        src_active[0] |=> irq_high_req;
    endproperty
    a_ext0_high: assert property (p_ext0_high) else $error("ext0 not high priority");

    property p_vector_gie;
        @(posedge mclk) disable iff (!resetn)
        vector_req |-> $past(ctrl_one_reg[irq_src_pkg::BIT_GIE]);
    endproperty
    a_vector_gie: assert property (p_vector_gie) else $error("vector without global enable");

    property p_shadow;
        @(posedge mclk) disable iff (!resetn)
        irq_entry |=> stack_push && shadow_working == $past(working_register) && stack_push_pc == $past(return_pc);
    endproperty
    a_shadow: assert property (p_shadow) else $error("context not saved on entry");

endmodule

`default_nettype wire

//--- core/irq_src_pkg.sv
// Constants for the interrupt source and reset-status block
package irq_src_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_RESET_CAUSE = 8'h00;
    localparam logic [7:0] OFF_CTRL_ONE    = 8'h04;
    localparam logic [7:0] OFF_CTRL_TWO    = 8'h08;
    localparam logic [7:0] OFF_CTRL_THREE  = 8'h0c;
    localparam logic [7:0] OFF_STATUS      = 8'h10;
    // Reset-cause fields
    localparam int BIT_PRIO_EN    = 7;
    localparam int BIT_SOFT_RESET = 4;
    localparam int BIT_WDOG       = 3;
    localparam int BIT_PDOWN      = 2;
    localparam int BIT_POWERON    = 1;
    localparam int BIT_BROWNOUT   = 0;
    localparam logic [7:0] RESET_CAUSE_RST = 8'h1c;
    localparam logic [7:0] RESET_CAUSE_WMASK = 8'h93;
    // Control one fields
    localparam int BIT_GIE       = 7;
    localparam int BIT_TMR0_EN   = 5;
    localparam int BIT_EXT0_EN   = 4;
    localparam int BIT_PCHG_EN   = 3;
    localparam int BIT_TMR0_FLAG = 2;
    localparam int BIT_EXT0_FLAG = 1;
    localparam int BIT_PCHG_FLAG = 0;
    // Control two fields
    localparam int BIT_EDGE_LSB   = 3;
    localparam int BIT_TMR0_PRIO  = 2;
    localparam int BIT_EXT3_PRIO  = 1;
    localparam int BIT_PCHG_PRIO  = 0;
    localparam int BIT_T16_MODE   = 7;
    localparam logic [7:0] CTRL_TWO_RST = 8'hff;
    // Control three fields
    localparam int BIT_EXT2_PRIO = 7;
    localparam int BIT_EXT1_PRIO = 6;
    localparam int BIT_EXT3_EN   = 5;
    localparam int BIT_EXT2_EN   = 4;
    localparam int BIT_EXT1_EN   = 3;
    localparam int BIT_EXT3_FLAG = 2;
    localparam int BIT_EXT2_FLAG = 1;
    localparam int BIT_EXT1_FLAG = 0;
    localparam logic [7:0] CTRL_THREE_RST = 8'hc0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- sim/core_model.sv
// Processor core model: sleep state, interrupt entry and live context
`timescale 1ns/100ps
`default_nettype none
module core_model #(
    parameter int PC_WIDTH = 21
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // Requests
    input  wire logic                sleep_en,
    input  wire logic                vector_req,
    // Core state
    output logic                     core_sleeping,
    output logic                     irq_entry,
    output logic [PC_WIDTH-1:0]      return_pc,
    output logic [7:0]               working_register,
    output logic [7:0]               core_status,
    output logic [7:0]               bank_select_register
);
    logic vec_reg;
    // Context moves every cycle so a late capture shows
    assign working_register     = return_pc[7:0];
    assign core_status          = return_pc[7:0] ^ 8'h5a;
    assign bank_select_register = return_pc[15:8];
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            return_pc     <= '0;
            core_sleeping <= 1'b0;
            irq_entry     <= 1'b0;
            vec_reg       <= 1'b0;
        end else begin
            return_pc     <= return_pc + 1'b1;
            core_sleeping <= sleep_en;
            vec_reg       <= vector_req;
            irq_entry     <= vector_req & ~vec_reg & ~core_sleeping;
        end
    end
endmodule
`default_nettype wire

//--- sim/test_interrupt_source_logic.sv
// Testbench for the interrupt source block
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_source_logic;
    logic        mclk = 0;
    logic        resetn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, timer_zero_count_low = 0, timer_zero_count_high = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  ext_irq_pins = 0;
    logic [7:4]  port_b_pins = 0, port_b_dir_in = 0;
    logic        port_b_access = 0, sleep_en = 0, core_sleeping, irq_entry, stack_push;
    logic        irq_high_req, irq_low_req, wake_req, vector_req;
    logic [20:0] return_pc, stack_push_pc, pc_e;
    logic [7:0]  working_register, core_status, bank_select_register, shadow_working, shadow_status, shadow_bank;
    logic [7:0]  w_e, s_e, b_e;
    int          err_count = 0, n_tests = 0, cyc = 0, n_push = 0;

    irq_src u_dut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_irq_pins, .port_b_pins, .port_b_dir_in, .port_b_access, .timer_zero_count_low,
        .timer_zero_count_high, .core_sleeping, .irq_entry, .return_pc, .working_register, .core_status,
        .bank_select_register, .irq_high_req, .irq_low_req, .wake_req, .vector_req, .stack_push,
        .stack_push_pc, .shadow_working, .shadow_status, .shadow_bank);
    core_model u_core (.mclk, .resetn, .sleep_en, .vector_req, .core_sleeping, .irq_entry, .return_pc,
        .working_register, .core_status, .bank_select_register);

    always #12.5 mclk = ~mclk;

    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        chk("write response", {30'h0, irq_src_pkg::RESP_OKAY}, {30'h0, s_axi_bresp});
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("register %h", a), {24'h0, e}, d);
        chk("read response", {30'h0, irq_src_pkg::RESP_OKAY}, {30'h0, r});
    endtask
    task automatic flags(input logic [3:0] e);
        logic [31:0] c1;
        rd(8'h04);
        c1 = d;
        rd(8'h0c);
        chk("external flags", {28'h0, e}, {28'h0, d[2:0], c1[1]});
    endtask
    task automatic end_of_test;
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (irq_entry === 1'b1) begin
            pc_e <= return_pc;
            w_e <= working_register;
            s_e <= core_status;
            b_e <= bank_select_register;
        end
        if (stack_push === 1'b1) begin
            n_push++;
            chk("pushed pc", {11'h0, pc_e}, {11'h0, stack_push_pc});
            chk("shadow", {8'h0, w_e, s_e, b_e}, {8'h0, shadow_working, shadow_status, shadow_bank});
        end
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(5);
        resetn <= 1;
        rchk(8'h00, irq_src_pkg::RESET_CAUSE_RST);
        rchk(8'h04, 8'h00);
        rchk(8'h08, irq_src_pkg::CTRL_TWO_RST);
        chk("default 8-bit timer mode", 1, d[irq_src_pkg::BIT_T16_MODE]);
        rchk(8'h0c, irq_src_pkg::CTRL_THREE_RST);
        wr(8'h00, 8'hff);
        rchk(8'h00, 8'h9f);
        wr(8'h00, 8'h80);
        rchk(8'h00, 8'h8c);
        rd(8'h20);
        chk("unmapped response", {30'h0, irq_src_pkg::RESP_SLVERR}, {30'h0, r});
        for (int p = 1; p >= 0; p--) begin
            wr(8'h08, p ? 8'hf8 : 8'h80);
            ext_irq_pins <= p ? 4'h0 : 4'hf;
            tick(6);
            wr(8'h04, 0);
            wr(8'h0c, 0);
            for (int i = 0; i < 4; i++) begin
                ext_irq_pins[i] <= p[0];
                tick(6);
                flags(4'h1 << i);
                wr(8'h04, 0);
                wr(8'h0c, 0);
                ext_irq_pins[i] <= !p[0];
                tick(6);
                flags(4'h0);
            end
        end
        ext_irq_pins[1] <= 0;
        tick(6);
        wr(8'h0c, 8'h09);
        tick(3);
        chk("high low", 2'b01, {irq_high_req, irq_low_req});
        wr(8'h0c, 8'h49);
        tick(3);
        chk("high low", 2'b10, {irq_high_req, irq_low_req});
        wr(8'h0c, 8'h41);
        tick(3);
        chk("high low", 2'b00, {irq_high_req, irq_low_req});
        ext_irq_pins[0] <= 0;
        tick(6);
        wr(8'h04, 8'h12);
        tick(3);
        chk("high low vector", 3'b100, {irq_high_req, irq_low_req, vector_req});
        sleep_en <= 1;
        tick(3);
        chk("wake", 1, wake_req);
        sleep_en <= 0;
        wr(8'h04, 8'h92);
        tick(5);
        chk("vector", 1, vector_req);
        chk("entries", 1, n_push);
        wr(8'h04, 8'h80);
        wr(8'h04, 8'h90);
        tick(3);
        chk("after reenable", 0, {irq_high_req, irq_low_req, vector_req});
        timer_zero_count_low <= 8'hff;
        tick(2);
        timer_zero_count_low <= 0;
        tick(3);
        rchk(8'h04, 8'h94);
        wr(8'h04, 8'h24);
        tick(3);
        chk("timer low", 2'b01, {irq_high_req, irq_low_req});
        wr(8'h08, 8'h84);
        tick(3);
        chk("timer high", 2'b10, {irq_high_req, irq_low_req});
        wr(8'h08, 8'h00);
        wr(8'h04, 0);
        timer_zero_count_low <= 8'hff;
        tick(2);
        timer_zero_count_low <= 0;
        tick(3);
        rchk(8'h04, 8'h00);
        {timer_zero_count_high, timer_zero_count_low} <= 16'hffff;
        tick(2);
        {timer_zero_count_high, timer_zero_count_low} <= 16'h0000;
        tick(3);
        rchk(8'h04, 8'h04);
        wr(8'h04, 0);
        port_b_dir_in <= 4'h7;
        port_b_access <= 1;
        tick(1);
        port_b_access <= 0;
        port_b_pins[7] <= 1;
        tick(4);
        rchk(8'h04, 8'h00);
        port_b_pins[4] <= 1;
        tick(4);
        rchk(8'h04, 8'h01);
        wr(8'h04, 8'h09);
        tick(3);
        chk("port low", 2'b01, {irq_high_req, irq_low_req});
        sleep_en <= 1;
        tick(3);
        chk("port wake", 1, wake_req);
        sleep_en <= 0;
        port_b_access <= 1;
        tick(1);
        port_b_access <= 0;
        wr(8'h04, 0);
        tick(3);
        rchk(8'h04, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
